// ---- rtl/vkc_pkg.sv ----
// Purpose: Shared constants and state type of the video key control processor.
// Assumes: 10-bit full-range luma, black at 0 and white at all ones.
// Notes: The state record is the whole register set of the keyer module.
package vkc_pkg;

	// ----------------------------------------
	// Widths and levels
	// ----------------------------------------
	localparam int W = 10;
	localparam int OPW = 11;
	localparam int RW = 21;
	localparam int LINE_N = 8;
	localparam int PIPE_N = 5;
	localparam logic [W-1:0] MAXV = 10'h3FF;
	localparam logic [W-1:0] MASK_THR = 10'h200;
	localparam logic [OPW-1:0] OPAC_FULL = 11'h400;
	localparam logic [RW-1:0] RECIP_ONE = 21'h100000;
	localparam logic [11:0] SS_THREE = 12'hBFD;
	localparam logic [2:0] CENTER = 3'h4;
	localparam logic [3:0] LAST_TAP = 4'h7;
	localparam int LATENCY = 11;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	typedef enum logic {
		MODE_CLIP_GAIN = 1'b0,
		MODE_HI_LO = 1'b1
	} vkc_mode_e;

	typedef enum logic {
		MSRC_WIPE = 1'b0,
		MSRC_VIDEO = 1'b1
	} vkc_msrc_e;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		logic [W-1:0] p_clip;
		logic [W-1:0] p_gain;
		logic [W-1:0] p_upper;
		logic [W-1:0] p_lower;
		logic [RW-1:0] p_recip;
		logic [LINE_N-1:0][W-1:0] cut_l;
		logic [LINE_N-1:0][W-1:0] bg_l;
		logic [LINE_N-1:0][W-1:0] fill_l;
		logic [LINE_N-1:0] v_l;
		logic [LINE_N-1:0] inh_l;
		logic [LINE_N-1:0] frc_l;
		logic [PIPE_N-1:0][W-1:0] bg_d;
		logic [PIPE_N-1:0][W-1:0] fill_d;
		logic [PIPE_N-1:0] v_d;
		logic [PIPE_N-1:0] inh_d;
		logic [PIPE_N-1:0] frc_d;
		logic [W-1:0] s1_cut;
		logic [W-1:0] s2_k;
		logic [W-1:0] s3_k;
		logic [W-1:0] s4_k;
		logic [W-1:0] s5_k;
		logic [RW-1:0] s5_bg;
		logic [RW-1:0] s5_fill;
		logic [W-1:0] video;
		logic [W-1:0] show;
		logic out_v;
	} vkc_state_s;

	localparam vkc_state_s ST_RST = '0;

endpackage : vkc_pkg

// ---- rtl/vkc_keyer.sv ----
// Purpose: Per-pixel luminance/linear keyer: cut to key control, shaping, mix.
// Assumes: One pixel per sys_clk; all video and controls come from sys_clk logic.
// Notes: Fixed latency of LATENCY cycles from pixel inputs to video_out and show_key_out.
`timescale 1ns/1ps

module vkc_keyer (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [vkc_pkg::W-1:0] bg_in,
	input wire logic [vkc_pkg::W-1:0] cut_in,
	input wire logic [vkc_pkg::W-1:0] fill_in,
	input wire logic [vkc_pkg::W-1:0] mask_video_in,
	input wire logic wipe_in,
	input wire vkc_pkg::vkc_mode_e adj_mode,
	input wire logic [vkc_pkg::W-1:0] clip_in,
	input wire logic [vkc_pkg::W-1:0] gain_in,
	input wire logic [vkc_pkg::W-1:0] upper_threshold,
	input wire logic [vkc_pkg::W-1:0] lower_threshold,
	input wire logic s_shape_en,
	input wire logic invert_en,
	input wire logic inhibit_en,
	input wire vkc_pkg::vkc_msrc_e inhibit_src,
	input wire logic force_en,
	input wire vkc_pkg::vkc_msrc_e force_src,
	input wire logic [vkc_pkg::OPW-1:0] opacity_in,
	input wire logic signed [2:0] key_offset,
	input wire logic [1:0] key_size,
	input wire logic core_en,
	input wire logic [vkc_pkg::W-1:0] core_level,
	output logic out_valid,
	output logic [vkc_pkg::W-1:0] video_out,
	output logic [vkc_pkg::W-1:0] show_key_out,
	output logic [vkc_pkg::W-1:0] clip_out,
	output logic [vkc_pkg::W-1:0] gain_out,
	output logic [vkc_pkg::W-1:0] upper_out,
	output logic [vkc_pkg::W-1:0] lower_out
);
	import vkc_pkg::*;

	vkc_state_s st;
	vkc_state_s next_st;

	// ----------------------------------------
	// Combinational scratch
	// ----------------------------------------
	logic [W:0] sum_hi;
	logic [W-1:0] half_gain;
	logic [W-1:0] hi_v;
	logic [W-1:0] lo_v;
	logic [W-1:0] span;
	logic [3:0] tap;
	logic [3:0] tj;
	logic [W-1:0] cut_min;
	logic [W-1:0] d_cut;
	logic [30:0] slope_p;
	logic [2*W-1:0] sq;
	logic [11:0] s_fac;
	logic [21:0] s_p;
	logic [W-1:0] k_m;
	logic [OPW-1:0] op;
	logic [RW-1:0] op_p;
	logic [W:0] kk;
	logic [RW-1:0] fill_p;
	logic [RW:0] mix;
	logic msk_v;

	always_comb begin
		next_st = st;
		sum_hi = '0;
		hi_v = '0;
		lo_v = '0;
		tj = '0;

		// ----------------------------------------
		// Threshold parameters
		// ----------------------------------------
		half_gain = gain_in >> 1;
		if (adj_mode == MODE_CLIP_GAIN) begin
			// Clip and gain stand as set; thresholds follow from them
			next_st.p_clip = clip_in;
			next_st.p_gain = gain_in;
			sum_hi = {1'b0, clip_in} + {1'b0, half_gain};
			next_st.p_upper = sum_hi[W] ? MAXV : sum_hi[W-1:0];
			next_st.p_lower = (clip_in > half_gain) ? clip_in - half_gain : '0;
		end else begin
			// Upper threshold from the larger input, lower from the smaller; clip and gain derived
			hi_v = (upper_threshold >= lower_threshold) ? upper_threshold : lower_threshold;
			lo_v = (upper_threshold >= lower_threshold) ? lower_threshold : upper_threshold;
			next_st.p_upper = hi_v;
			next_st.p_lower = lo_v;
			next_st.p_gain = hi_v - lo_v;
			sum_hi = {1'b0, hi_v} + {1'b0, lo_v};
			next_st.p_clip = sum_hi[W:1];
		end
		// Reciprocal of the edge width, so pixels need only a multiply
		span = st.p_upper - st.p_lower;
		next_st.p_recip = (span == '0) ? RECIP_ONE : RECIP_ONE / {11'h000, span};

		// ----------------------------------------
		// Input lines: cut offset and narrowing
		// ----------------------------------------
		next_st.cut_l = {st.cut_l[LINE_N-2:0], cut_in};
		next_st.bg_l = {st.bg_l[LINE_N-2:0], bg_in};
		next_st.fill_l = {st.fill_l[LINE_N-2:0], fill_in};
		next_st.v_l = {st.v_l[LINE_N-2:0], in_valid};
		msk_v = (mask_video_in >= MASK_THR);
		next_st.inh_l = {st.inh_l[LINE_N-2:0], inhibit_en & ((inhibit_src == MSRC_WIPE) ? wipe_in : msk_v)};
		next_st.frc_l = {st.frc_l[LINE_N-2:0], force_en & ((force_src == MSRC_WIPE) ? wipe_in : msk_v)};

		// Cut tap moves around the fixed fill tap
		tap = {1'b0, CENTER} - {key_offset[2], key_offset};
		// Offset -4 would point past the oldest tap; hold it at the end
		if (tap > LAST_TAP) begin
			tap = LAST_TAP;
		end
		cut_min = st.cut_l[tap[2:0]];
		// Minimum over a short window erodes bright cut edges
		for (int j = 1; j < 4; j++) begin
			tj = tap + 4'(j);
			if (2'(j) <= key_size && tj <= LAST_TAP && st.cut_l[tj[2:0]] < cut_min) begin
				cut_min = st.cut_l[tj[2:0]];
			end
		end

		// ----------------------------------------
		// Sample alignment through every stage
		// ----------------------------------------
		next_st.bg_d = {st.bg_d[PIPE_N-2:0], st.bg_l[CENTER]};
		next_st.fill_d = {st.fill_d[PIPE_N-2:0], st.fill_l[CENTER]};
		next_st.v_d = {st.v_d[PIPE_N-2:0], st.v_l[CENTER]};
		next_st.inh_d = {st.inh_d[PIPE_N-2:0], st.inh_l[CENTER]};
		next_st.frc_d = {st.frc_d[PIPE_N-2:0], st.frc_l[CENTER]};
		next_st.s1_cut = cut_min;

		// ----------------------------------------
		// Stage 2: linear key control
		// ----------------------------------------
		// Equal thresholds never reach the slope branch: hard edge
		d_cut = st.s1_cut - st.p_lower;
		slope_p = 31'(d_cut) * 31'(st.p_recip);
		if (st.s1_cut >= st.p_upper) begin
			next_st.s2_k = MAXV;
		end else if (st.s1_cut <= st.p_lower) begin
			next_st.s2_k = '0;
		end else begin
			next_st.s2_k = (slope_p[30:20] != '0) ? MAXV : slope_p[19:10];
		end

		// ----------------------------------------
		// Stage 3: S-curve, 3x^2 - 2x^3
		// ----------------------------------------
		sq = st.s2_k * st.s2_k;
		s_fac = SS_THREE - {1'b0, st.s2_k, 1'b0};
		s_p = 22'(sq[2*W-1:W]) * 22'(s_fac);
		if (!s_shape_en || st.s2_k == MAXV) begin
			// Bypass for linear keys; full opacity pinned so thresholds stay
			next_st.s3_k = st.s2_k;
		end else begin
			next_st.s3_k = (s_p[21:20] != '0) ? MAXV : s_p[19:10];
		end

		// ----------------------------------------
		// Stage 4: invert, masks, opacity
		// ----------------------------------------
		k_m = invert_en ? MAXV - st.s3_k : st.s3_k;
		if (st.frc_d[2]) begin
			k_m = MAXV;
		end
		// Keep-out wins over always-key where both are set
		if (st.inh_d[2]) begin
			k_m = '0;
		end
		op = (opacity_in > OPAC_FULL) ? OPAC_FULL : opacity_in;
		op_p = RW'(k_m) * RW'(op);
		next_st.s4_k = op_p[19:10];

		// ----------------------------------------
		// Stage 5: shape fill, cut hole, coring
		// ----------------------------------------
		// Lift 1023 to 1024 so a full key leaves no background leak
		kk = {1'b0, st.s4_k} + {10'h000, st.s4_k[W-1]};
		fill_p = RW'(st.fill_d[3]) * RW'(kk);
		next_st.s5_bg = RW'(st.bg_d[3]) * RW'(11'h400 - kk);
		if (core_en && fill_p[19:10] < core_level) begin
			next_st.s5_fill = '0;
		end else begin
			next_st.s5_fill = fill_p;
		end
		next_st.s5_k = st.s4_k;

		// ----------------------------------------
		// Stage 6: sum and outputs
		// ----------------------------------------
		mix = {1'b0, st.s5_bg} + {1'b0, st.s5_fill};
		next_st.video = (mix[RW:20] != '0) ? MAXV : mix[19:10];
		next_st.show = st.s5_k;
		next_st.out_v = st.v_d[4];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign out_valid = st.out_v;
	assign video_out = st.video;
	assign show_key_out = st.show;
	assign clip_out = st.p_clip;
	assign gain_out = st.p_gain;
	assign upper_out = st.p_upper;
	assign lower_out = st.p_lower;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_upper_calc;
		(adj_mode == MODE_CLIP_GAIN && ({1'b0, clip_in} + {2'b00, gain_in[W-1:1]}) <= {1'b0, MAXV})
			|=> upper_out == $past(clip_in + (gain_in >> 1));
	endproperty
	a_upper_calc: assert property (p_upper_calc) else $error("upper threshold not clip plus half gain");

	property p_lower_calc;
		(adj_mode == MODE_CLIP_GAIN && clip_in >= (gain_in >> 1))
			|=> lower_out == $past(clip_in - (gain_in >> 1)) && gain_out == $past(gain_in);
	endproperty
	a_lower_calc: assert property (p_lower_calc) else $error("lower threshold not clip minus half gain");

	property p_hilo_indep;
		(adj_mode == MODE_HI_LO && upper_threshold >= lower_threshold && $stable(upper_threshold))
			|=> upper_out == $past(upper_threshold) && lower_out == $past(lower_threshold);
	endproperty
	a_hilo_indep: assert property (p_hilo_indep) else $error("threshold moved with the other");

	property p_hilo_consist;
		adj_mode == MODE_HI_LO ##1 adj_mode == MODE_HI_LO
			|=> gain_out == upper_out - lower_out && clip_out == W'(({1'b0, upper_out} + {1'b0, lower_out}) >> 1);
	endproperty
	a_hilo_consist: assert property (p_hilo_consist) else $error("clip and gain inconsistent");

	property p_opaque;
		st.s1_cut >= st.p_upper |=> st.s2_k == MAXV;
	endproperty
	a_opaque: assert property (p_opaque) else $error("cut above upper threshold not opaque");

	property p_transparent;
		(st.s1_cut < st.p_lower) |=> st.s2_k == '0;
	endproperty
	a_transparent: assert property (p_transparent) else $error("cut below lower threshold not clear");

	property p_sshape_ends;
		(st.s2_k == MAXV || st.s2_k == '0) |=> st.s3_k == $past(st.s2_k);
	endproperty
	a_sshape_ends: assert property (p_sshape_ends) else $error("s-curve moved an end point");

	property p_invert;
		(invert_en && !st.frc_d[2] && !st.inh_d[2] && opacity_in >= OPAC_FULL && st.s3_k == '0)
			|=> st.s4_k == MAXV;
	endproperty
	a_invert: assert property (p_invert) else $error("inverted clear key not opaque");

	property p_inhibit;
		st.inh_d[2] |=> st.s4_k == '0 ##2 show_key_out == '0;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("keep-out area keyed");

	property p_opacity_zero;
		opacity_in == '0 |-> ##3 show_key_out == '0;
	endproperty
	a_opacity_zero: assert property (p_opacity_zero) else $error("zero opacity key visible");

	property p_latency;
		in_valid |-> ##11 out_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("pixel not out after fixed latency");

	property p_cut_offset;
		(key_size == 2'h0 && key_offset == 3'sh2) |=> st.s1_cut == $past(st.cut_l[2]);
	endproperty
	a_cut_offset: assert property (p_cut_offset) else $error("cut tap not moved by the offset");

	property p_cut_far;
		(key_size == 2'h0 && key_offset == 3'sh4) |=> st.s1_cut == $past(st.cut_l[7]);
	endproperty
	a_cut_far: assert property (p_cut_far) else $error("largest offset left the cut line");

	property p_cut_erode;
		(key_size == 2'h1 && key_offset == 3'sh0)
			|=> st.s1_cut == (($past(st.cut_l[4]) < $past(st.cut_l[5])) ? $past(st.cut_l[4]) : $past(st.cut_l[5]));
	endproperty
	a_cut_erode: assert property (p_cut_erode) else $error("key size did not narrow the cut");

	property p_sshape_bypass;
		!s_shape_en |=> st.s3_k == $past(st.s2_k);
	endproperty
	a_sshape_bypass: assert property (p_sshape_bypass) else $error("s-curve applied while bypassed");

	property p_force;
		(st.frc_d[2] && !st.inh_d[2] && opacity_in >= OPAC_FULL) |=> st.s4_k == MAXV;
	endproperty
	a_force: assert property (p_force) else $error("always-key area not opaque");

	property p_opacity_full;
		(opacity_in >= OPAC_FULL && !invert_en && !st.frc_d[2] && !st.inh_d[2])
			|=> st.s4_k == $past(st.s3_k);
	endproperty
	a_opacity_full: assert property (p_opacity_full) else $error("full opacity scaled the key");

	property p_full_key_hole;
		st.s4_k == MAXV |=> st.s5_bg == '0;
	endproperty
	a_full_key_hole: assert property (p_full_key_hole) else $error("background leaks through opaque key");

	property p_coring;
		(core_en && st.fill_d[3] < core_level) |=> st.s5_fill == '0;
	endproperty
	a_coring: assert property (p_coring) else $error("near-black fill not cored");

endmodule : vkc_keyer

// ---- test/vkc_src.sv ----
// Purpose: Video source model for background, cut, fill and mask streams.
// Assumes: The bench hands over the next pixel every clock.
// Notes: Outputs launch from flops and are zero during reset.
`timescale 1ns/1ps
module vkc_src (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic next_valid,
	input wire logic [vkc_pkg::W-1:0] next_bg,
	input wire logic [vkc_pkg::W-1:0] next_cut,
	input wire logic [vkc_pkg::W-1:0] next_fill,
	input wire logic [vkc_pkg::W-1:0] next_mask,
	input wire logic next_wipe,
	output logic in_valid,
	output logic [vkc_pkg::W-1:0] bg_in,
	output logic [vkc_pkg::W-1:0] cut_in,
	output logic [vkc_pkg::W-1:0] fill_in,
	output logic [vkc_pkg::W-1:0] mask_video_in,
	output logic wipe_in
);
	import vkc_pkg::*;
	// Launch off flops so the keyer never samples a moving value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{in_valid, bg_in, cut_in, fill_in, mask_video_in, wipe_in} <= '0;
		end else begin
			{in_valid, bg_in, cut_in, fill_in, mask_video_in, wipe_in} <=
				{next_valid, next_bg, next_cut, next_fill, next_mask, next_wipe};
		end
	end
endmodule : vkc_src

// ---- test/tb_video_key_control_processor.sv ----
// Purpose: Self-checking bench of the keyer with random settings.
// Assumes: Each setting is held until the pipeline holds one flat pixel.
// Notes: Flat pixels hide cut offset and size; the keyer's own assertions cover those.
`timescale 1ns/1ps
module tb_video_key_control_processor;
	import vkc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n;
	logic next_valid = 1'b0;
	logic next_wipe = 1'b0;
	logic [W-1:0] next_bg = '0, next_cut = '0, next_fill = '0, next_mask = '0;
	logic in_valid, wipe_in, out_valid;
	logic [W-1:0] bg_in, cut_in, fill_in, mask_video_in, video_out, show_key_out;
	logic [W-1:0] clip_out, gain_out, upper_out, lower_out, ek, ev, ec, eg, eu, el;
	vkc_mode_e adj_mode = MODE_CLIP_GAIN;
	logic [W-1:0] clip_in = '0, gain_in = '0, upper_threshold = '0, lower_threshold = '0, core_level = '0;
	logic s_shape_en = 1'b0, invert_en = 1'b0, inhibit_en = 1'b0, force_en = 1'b0, core_en = 1'b0;
	vkc_msrc_e inhibit_src = MSRC_WIPE, force_src = MSRC_WIPE;
	logic [OPW-1:0] opacity_in = '0;
	logic signed [2:0] key_offset = '0;
	logic [1:0] key_size = '0;
	logic [10:0] hist = '0;
	int n_errors = 0, num_checks = 0, ph = 0;

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	vkc_src u_vkc_src (.sys_clk(sys_clk), .rst_n(rst_n), .next_valid(next_valid), .next_bg(next_bg),
		.next_cut(next_cut), .next_fill(next_fill), .next_mask(next_mask), .next_wipe(next_wipe),
		.in_valid(in_valid), .bg_in(bg_in), .cut_in(cut_in), .fill_in(fill_in),
		.mask_video_in(mask_video_in), .wipe_in(wipe_in));

	vkc_keyer u_vkc_keyer (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid), .bg_in(bg_in),
		.cut_in(cut_in), .fill_in(fill_in), .mask_video_in(mask_video_in), .wipe_in(wipe_in),
		.adj_mode(adj_mode), .clip_in(clip_in), .gain_in(gain_in), .upper_threshold(upper_threshold),
		.lower_threshold(lower_threshold), .s_shape_en(s_shape_en), .invert_en(invert_en),
		.inhibit_en(inhibit_en), .inhibit_src(inhibit_src), .force_en(force_en), .force_src(force_src),
		.opacity_in(opacity_in), .key_offset(key_offset), .key_size(key_size), .core_en(core_en),
		.core_level(core_level), .out_valid(out_valid), .video_out(video_out),
		.show_key_out(show_key_out), .clip_out(clip_out), .gain_out(gain_out),
		.upper_out(upper_out), .lower_out(lower_out));

	task automatic chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic check_reset;
		chk("video_rst", 10'h000, video_out);
		chk("show_rst", 10'h000, show_key_out);
		chk("valid_rst", 10'h000, {9'h0, out_valid});
		chk("upper_rst", 10'h000, upper_out);
		chk("lower_rst", 10'h000, lower_out);
	endtask : check_reset

	task automatic stop_test;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// Expected key, video and effective parameters for the held pixel
	function automatic void f_exp(output logic [W-1:0] k, v, c, g, u, l);
		logic [31:0] t, p, kk, op;
		logic fin, iin;
		if (adj_mode == MODE_HI_LO) begin
			u = (upper_threshold > lower_threshold) ? upper_threshold : lower_threshold;
			l = (upper_threshold > lower_threshold) ? lower_threshold : upper_threshold;
			c = W'((32'(u) + 32'(l)) >> 1);
			g = u - l;
		end else begin
			u = (11'(clip_in) + 11'(gain_in >> 1) > 11'h3FF) ? 10'h3FF : clip_in + (gain_in >> 1);
			l = (clip_in > (gain_in >> 1)) ? clip_in - (gain_in >> 1) : 10'h000;
			c = clip_in;
			g = gain_in;
		end
		if (next_cut >= u) t = 32'h3FF;
		else if (next_cut <= l) t = 32'h0;
		else t = (32'(next_cut - l) * (32'h100000 / 32'(u - l))) >> 10;
		if (t > 32'h3FF) t = 32'h3FF;
		if (s_shape_en && t != 32'h3FF) t = (((t * t) >> 10) * (32'(SS_THREE) - 2 * t)) >> 10;
		if (t > 32'h3FF) t = 32'h3FF;
		if (invert_en) t = 32'h3FF - t;
		fin = force_en && ((force_src == MSRC_VIDEO) ? (next_mask >= MASK_THR) : next_wipe);
		iin = inhibit_en && ((inhibit_src == MSRC_VIDEO) ? (next_mask >= MASK_THR) : next_wipe);
		if (fin) t = 32'h3FF;
		if (iin) t = 32'h0;
		op = (opacity_in > OPAC_FULL) ? 32'h400 : 32'(opacity_in);
		t = (t * op) >> 10;
		k = t[W-1:0];
		kk = t + 32'(t[9]);
		p = 32'(next_fill) * kk;
		if (core_en && (p >> 10) < 32'(core_level)) p = 32'h0;
		t = (32'(next_bg) * (32'h400 - kk) + p) >> 10;
		v = (t > 32'h3FF) ? 10'h3FF : t[W-1:0];
	endfunction : f_exp

	always @(posedge sys_clk) begin
		next_valid <= 1'($urandom);
		if (rst_n && ph > 12) chk("out_valid", {9'h0, hist[10]}, {9'h0, out_valid});
		hist <= {hist[9:0], in_valid};
		ph <= rst_n ? ph + 1 : 0;
	end

	initial begin
		rst_n = 1'b0;
		void'($urandom(32'h07BDF83D));
		repeat (11) @(posedge sys_clk);
		@(negedge sys_clk);
		check_reset();
		@(posedge sys_clk);
		rst_n <= 1'b1;
		// First five passes: zero and full softness, zero and over-range opacity, equal thresholds
		for (int i = 0; i < 150; i++) begin
			// One short reset mid-run; outputs must clear and keying resume
			if (i == 75) begin
				@(posedge sys_clk);
				rst_n <= 1'b0;
				@(negedge sys_clk);
				check_reset();
				@(posedge sys_clk);
				rst_n <= 1'b1;
			end
			@(posedge sys_clk);
			next_bg <= W'($urandom);
			next_cut <= W'($urandom);
			next_fill <= W'($urandom);
			next_mask <= W'($urandom);
			next_wipe <= 1'($urandom);
			adj_mode <= (i == 4) ? MODE_HI_LO : (i < 2) ? MODE_CLIP_GAIN : vkc_mode_e'($urandom_range(0, 1));
			clip_in <= W'($urandom);
			gain_in <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : W'($urandom);
			upper_threshold <= (i == 4) ? 10'h180 : W'($urandom);
			lower_threshold <= (i == 4) ? 10'h180 : W'($urandom);
			s_shape_en <= 1'($urandom);
			invert_en <= 1'($urandom);
			inhibit_en <= ($urandom_range(0, 3) == 0);
			force_en <= ($urandom_range(0, 3) == 0);
			inhibit_src <= vkc_msrc_e'($urandom_range(0, 1));
			force_src <= vkc_msrc_e'($urandom_range(0, 1));
			opacity_in <= (i == 2) ? 11'h000 : (i == 3) ? 11'h7FF : OPW'($urandom_range(0, 1279));
			key_offset <= 3'($urandom);
			key_size <= 2'($urandom);
			core_en <= 1'($urandom);
			core_level <= W'($urandom_range(0, 255));
			repeat (16) @(negedge sys_clk);
			f_exp(ek, ev, ec, eg, eu, el);
			chk("show_key", ek, show_key_out);
			chk("video", ev, video_out);
			chk("clip_out", ec, clip_out);
			chk("gain_out", eg, gain_out);
			chk("upper_out", eu, upper_out);
			chk("lower_out", el, lower_out);
		end
		stop_test();
	end
endmodule : tb_video_key_control_processor
